// ---- sched_pkg.sv ----
// Constants and types shared by the scheduler, store queue and branch predictor
package sched_pkg;
  localparam int ENTRIES     = 24;
  localparam int GROUP       = 4;
  localparam int MAX_INSTR   = 12;
  localparam int ISSUE_BUSES = 6;
  localparam int RETIRE_W    = 4;
  localparam int MAX_BRANCH  = 7;
  localparam int TAG_W       = 5;
  localparam int HIST_W      = 13;
  localparam int RAS_DEPTH   = 16;
  localparam int TC_ENTRIES  = 16;
  localparam int TC_BYTES    = 16;
  localparam int SQ_DEPTH    = 4;
  // Bus numbers
  localparam int BUS_ST = 0;
  localparam int BUS_LD = 1;
  localparam int BUS_BR = 2;
  localparam int BUS_X  = 3;
  localparam int BUS_Y  = 4;
  localparam int BUS_FP = 5;
  // Latencies and occupancies in clocks, and the predictor counter reset value
  localparam logic [1:0] STORE_LAT = 2'h1;
  localparam logic [1:0] LOAD_LAT  = 2'h2;
  localparam logic [1:0] Y_LAT     = 2'h1;
  localparam logic [1:0] FP_LAT    = 2'h2;
  localparam logic [1:0] FP_OCC    = 2'h2;
  localparam logic [1:0] CTR_RESET = 2'h1;
  typedef enum logic [2:0] {
    K_NOP, K_STORE, K_LOAD, K_BRANCH, K_X_ONLY, K_XY_ALU, K_SHARED, K_FP
  } uop_kind_e;
  typedef enum logic [2:0] {B_NONE, B_COND, B_UNCOND, B_CALL, B_RET} br_kind_e;
endpackage : sched_pkg

// ---- store_queue.sv ----
// In-order store queue draining one store per clock
`timescale 1ns/1ns
module store_queue #(
  parameter int DEPTH = sched_pkg::SQ_DEPTH,
  parameter int W     = sched_pkg::TAG_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Enqueue
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_tag,
  // Head leaving this cycle
  output logic              pop_valid,
  output logic [W-1:0]      pop_tag,
  // Store execution
  output logic              exec_valid,
  output logic [W-1:0]      exec_tag
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] rd_reg;
  logic [PW-1:0] wr_reg;
  logic [PW:0]   cnt_reg;
  logic          push;

  assign in_ready  = cnt_reg != (PW+1)'(DEPTH);
  assign pop_valid = cnt_reg != '0;
  assign pop_tag   = mem[rd_reg];
  assign push      = in_valid && in_ready;

  always_ff @(posedge clk) begin
    if (push) mem[wr_reg] <= in_tag;
  end

  // Head leaves every clock, so stores run in arrival order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop_valid) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop_valid);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exec_valid <= 1'b0;
      exec_tag   <= '0;
    end else begin
      exec_valid <= pop_valid;
      exec_tag   <= pop_tag;
    end
  end
endmodule : store_queue

// ---- branch_predictor.sv ----
// Direction history, target adders, return stack and target cache
`timescale 1ns/1ns
module branch_predictor (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Decoded group
  input  wire logic         grp_fire,
  input  wire logic [31:0]  grp_pc,
  input  wire logic [11:0]  slot_bkind,
  input  wire logic [15:0]  slot_end,
  input  wire logic [63:0]  slot_disp,
  output logic [3:0]        pred_taken,
  output logic [51:0]       pred_hidx,
  // Resolution
  input  wire logic         res_update,
  input  wire logic         res_taken,
  input  wire logic [12:0]  res_hidx,
  input  wire logic         res_mispredict,
  input  wire logic [31:0]  res_target,
  // Target cache fill
  input  wire logic         tc_fill_valid,
  input  wire logic [31:0]  tc_fill_addr,
  input  wire logic [127:0] tc_fill_data,
  // Fetch redirect
  output logic              redir_valid,
  output logic [31:0]       redir_addr,
  output logic              tc_hit,
  output logic [127:0]      tc_data
);
  localparam int HW = sched_pkg::HIST_W;
  localparam int RW = $clog2(sched_pkg::RAS_DEPTH);
  localparam int CW = $clog2(sched_pkg::TC_ENTRIES);
  localparam int OW = $clog2(sched_pkg::TC_BYTES);
  localparam int GW = 32 - CW - OW;
  logic [1:0]    pht_reg [2**HW];
  logic [HW-1:0] ghr_reg;
  logic [31:0]   ras_reg [sched_pkg::RAS_DEPTH];
  logic [RW-1:0] sp_reg;
  logic          tcv_reg [sched_pkg::TC_ENTRIES];
  logic [GW-1:0] tct_reg [sched_pkg::TC_ENTRIES];
  logic [127:0]  tcd_reg [sched_pkg::TC_ENTRIES];
  logic          any;
  logic [31:0]   sel_addr;
  logic [31:0]   sel_pc;
  sched_pkg::br_kind_e sel_kind;
  logic [CW-1:0] ti;

  always_comb begin
    logic [31:0] pc;
    logic [31:0] cand;
    logic [HW-1:0] hi;
    sched_pkg::br_kind_e bk;
    pc = '0;
    cand = '0;
    hi = '0;
    bk = sched_pkg::B_NONE;
    any = 1'b0;
    sel_addr = '0;
    sel_pc = '0;
    sel_kind = sched_pkg::B_NONE;
    for (int s = 0; s < sched_pkg::GROUP; s++) begin
      bk = sched_pkg::br_kind_e'(slot_bkind[s*3 +: 3]);
      pc = grp_pc + 32'(slot_end[s*4 +: 4]);
      cand = pc + {{16{slot_disp[s*16+15]}}, slot_disp[s*16 +: 16]};
      if (bk == sched_pkg::B_RET) cand = ras_reg[sp_reg - 1'b1];
      hi = pc[HW-1:0] ^ ghr_reg;
      pred_hidx[s*HW +: HW] = hi;
      pred_taken[s] = (bk == sched_pkg::B_COND) ? pht_reg[hi][1]
                                                : (bk != sched_pkg::B_NONE);
      if (pred_taken[s] && !any) begin
        any = 1'b1;
        sel_addr = cand;
        sel_pc = pc;
        sel_kind = bk;
      end
    end
  end
  assign ti = sel_addr[OW +: CW];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_reg <= '0;
    end else if (grp_fire && any) begin
      if (sel_kind == sched_pkg::B_CALL) begin
        ras_reg[sp_reg] <= sel_pc;
        sp_reg <= sp_reg + 1'b1;
      end else if (sel_kind == sched_pkg::B_RET) begin
        sp_reg <= sp_reg - 1'b1;
      end
    end
  end

  // Trained only by executed branches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**HW; i++) pht_reg[i] <= sched_pkg::CTR_RESET;
      ghr_reg <= '0;
    end else if (res_update) begin
      if (res_taken && pht_reg[res_hidx] != 2'h3) pht_reg[res_hidx] <= pht_reg[res_hidx] + 2'h1;
      if (!res_taken && pht_reg[res_hidx] != 2'h0) pht_reg[res_hidx] <= pht_reg[res_hidx] - 2'h1;
      ghr_reg <= {ghr_reg[HW-2:0], res_taken};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < sched_pkg::TC_ENTRIES; i++) tcv_reg[i] <= 1'b0;
    end else if (tc_fill_valid) begin
      tcv_reg[tc_fill_addr[OW +: CW]] <= 1'b1;
      tct_reg[tc_fill_addr[OW +: CW]] <= tc_fill_addr[31 -: GW];
      tcd_reg[tc_fill_addr[OW +: CW]] <= tc_fill_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      redir_valid <= 1'b0;
      redir_addr  <= '0;
      tc_hit      <= 1'b0;
      tc_data     <= '0;
    end else begin
      redir_valid <= res_mispredict || (grp_fire && any);
      redir_addr  <= res_mispredict ? res_target : sel_addr;
      tc_hit      <= !res_mispredict && grp_fire && any && tcv_reg[ti]
                     && tct_reg[ti] == sel_addr[31 -: GW];
      tc_data     <= tcd_reg[ti];
    end
  end
endmodule : branch_predictor

// ---- ooo_scheduler.sv ----
// Out-of-order scheduler: buffer, oldest-first issue, in-order retire, recovery
`timescale 1ns/1ns
module ooo_scheduler #(
  parameter int SQ_DEPTH = sched_pkg::SQ_DEPTH
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Decoded group of four
  input  wire logic         grp_valid,
  output logic              grp_ready,
  input  wire logic [11:0]  slot_kind,
  input  wire logic [7:0]   slot_lat,
  input  wire logic [3:0]   slot_occ,
  input  wire logic [3:0]   slot_last,
  input  wire logic [31:0]  grp_pc,
  input  wire logic [11:0]  slot_bkind,
  input  wire logic [15:0]  slot_end,
  input  wire logic [63:0]  slot_disp,
  // Issue buses: store, load, branch, X, Y, float
  output logic [5:0]        iss_valid,
  output logic [29:0]       iss_tag,
  // Store execution
  output logic              st_exec_valid,
  output logic [4:0]        st_exec_tag,
  // Branch resolution
  input  wire logic         res_valid,
  input  wire logic [4:0]   res_tag,
  input  wire logic         res_taken,
  input  wire logic [31:0]  res_target,
  // Retirement
  output logic [3:0]        ret_valid,
  output logic [19:0]       ret_tag,
  // Recovery
  output logic              flush_valid,
  output logic [4:0]        flush_tag,
  // Fetch
  output logic              redir_valid,
  output logic [31:0]       redir_addr,
  output logic              tc_hit,
  output logic [127:0]      tc_data,
  input  wire logic         tc_fill_valid,
  input  wire logic [31:0]  tc_fill_addr,
  input  wire logic [127:0] tc_fill_data
);
  localparam int N  = sched_pkg::ENTRIES;
  localparam int TW = sched_pkg::TAG_W;
  localparam int NB = sched_pkg::ISSUE_BUSES;
  localparam int G  = sched_pkg::GROUP;
  localparam int HW = sched_pkg::HIST_W;
  typedef logic [TW-1:0] tag_t;

  // Entry state
  logic                 valid_reg  [N];
  logic                 issued_reg [N];
  logic                 done_reg   [N];
  logic [1:0]           cnt_reg    [N];
  sched_pkg::uop_kind_e kind_reg   [N];
  logic [1:0]           lat_reg    [N];
  logic                 occ_reg    [N];
  logic                 last_reg   [N];
  logic                 pred_reg   [N];
  logic [HW-1:0]        hidx_reg   [N];
  tag_t                 head_reg;
  logic [TW-1:0]        count_reg;
  logic [1:0]           busy_reg   [NB];
  logic                 grp_ready_reg;

  // Combinational
  logic [N-1:0]         elig [NB];
  logic [TW:0]          pick [NB];
  tag_t                 tail;
  int                   icnt;
  int                   bcnt;
  int                   gi;
  int                   gb;
  int                   ret_n;
  int                   age_b;
  int                   count_next;
  logic                 mispredict;
  logic                 res_ok;
  logic                 fire;
  logic                 sq_ready;
  logic                 sq_pop;
  tag_t                 sq_pop_tag;
  logic [3:0]           pred_taken;
  logic [51:0]          pred_hidx;

  function automatic tag_t wrap(input int v);
    return tag_t'(v % N);
  endfunction : wrap

  function automatic int age(input tag_t i, input tag_t h);
    return (int'(i) - int'(h) + N) % N;
  endfunction : age

  // Oldest set bit of m, counting from the head
  function automatic logic [TW:0] oldest(input logic [N-1:0] m, input tag_t h);
    logic [TW:0] r;
    r = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (m[wrap(int'(h) + k)]) r = {1'b1, wrap(int'(h) + k)};
    end
    return r;
  endfunction : oldest

  function automatic logic [1:0] issue_lat(input int b, input tag_t i);
    case (b)
      sched_pkg::BUS_LD: issue_lat = sched_pkg::LOAD_LAT;
      sched_pkg::BUS_X:  issue_lat = lat_reg[i];
      sched_pkg::BUS_Y:  issue_lat = (kind_reg[i] == sched_pkg::K_XY_ALU) ? sched_pkg::Y_LAT
                                                                         : lat_reg[i];
      sched_pkg::BUS_FP: issue_lat = sched_pkg::FP_LAT;
      default:           issue_lat = 2'h0;
    endcase
  endfunction : issue_lat

  assign tail = wrap(int'(head_reg) + int'(count_reg));

  // Eligibility per bus, walked oldest first
  always_comb begin
    logic older_open;
    tag_t idx;
    older_open = 1'b0;
    idx = '0;
    for (int b = 0; b < NB; b++) elig[b] = '0;
    for (int k = 0; k < N; k++) begin
      idx = wrap(int'(head_reg) + k);
      if (valid_reg[idx] && !issued_reg[idx]) begin
        case (kind_reg[idx])
          sched_pkg::K_STORE:  elig[sched_pkg::BUS_ST][idx] = !older_open && sq_ready;
          sched_pkg::K_LOAD:   elig[sched_pkg::BUS_LD][idx] = 1'b1;
          sched_pkg::K_BRANCH: elig[sched_pkg::BUS_BR][idx] = 1'b1;
          sched_pkg::K_X_ONLY: elig[sched_pkg::BUS_X][idx] = busy_reg[sched_pkg::BUS_X] == 2'h0;
          sched_pkg::K_XY_ALU, sched_pkg::K_SHARED: begin
            elig[sched_pkg::BUS_X][idx] = busy_reg[sched_pkg::BUS_X] == 2'h0;
            elig[sched_pkg::BUS_Y][idx] = busy_reg[sched_pkg::BUS_Y] == 2'h0;
          end
          sched_pkg::K_FP:     elig[sched_pkg::BUS_FP][idx] = busy_reg[sched_pkg::BUS_FP] == 2'h0;
          default: ;
        endcase
      end
      if (valid_reg[idx] && kind_reg[idx] == sched_pkg::K_BRANCH && !done_reg[idx]) begin
        older_open = 1'b1;
      end
    end
  end

  // One pick per bus; Y never takes the X pick
  always_comb begin
    logic [N-1:0] xmask;
    xmask = '0;
    for (int b = 0; b < NB; b++) begin
      pick[b] = oldest((b == sched_pkg::BUS_Y) ? (elig[b] & ~xmask) : elig[b], head_reg);
      if (b == sched_pkg::BUS_X && pick[b][TW]) xmask[pick[b][TW-1:0]] = 1'b1;
    end
  end

  // Occupancy of the buffer and the group on offer
  always_comb begin
    icnt = 0;
    bcnt = 0;
    gi = 0;
    gb = 0;
    for (int i = 0; i < N; i++) begin
      if (valid_reg[i] && last_reg[i]) icnt++;
      if (valid_reg[i] && kind_reg[i] == sched_pkg::K_BRANCH && !done_reg[i]) bcnt++;
    end
    for (int s = 0; s < G; s++) begin
      if (slot_last[s]) gi++;
      if (slot_kind[s*3 +: 3] == sched_pkg::K_BRANCH) gb++;
    end
  end

  // In-order retirement from the head, stopping at the first unfinished entry
  always_comb begin
    logic stop;
    stop = 1'b0;
    ret_n = 0;
    for (int k = 0; k < sched_pkg::RETIRE_W; k++) begin
      if (!stop && k < int'(count_reg) && done_reg[wrap(int'(head_reg) + k)]) begin
        ret_n++;
      end else begin
        stop = 1'b1;
      end
    end
  end

  assign res_ok = res_valid && valid_reg[res_tag] && !done_reg[res_tag]
                  && kind_reg[res_tag] == sched_pkg::K_BRANCH;
  assign mispredict = res_ok && (res_taken != pred_reg[res_tag]);
  assign age_b = age(res_tag, head_reg);
  assign fire = grp_valid && grp_ready_reg && !mispredict;
  assign count_next = (mispredict ? age_b + 1 : int'(count_reg) + (fire ? G : 0)) - ret_n;

  // Entry state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        valid_reg[i]  <= 1'b0;
        issued_reg[i] <= 1'b0;
        done_reg[i]   <= 1'b0;
        cnt_reg[i]    <= 2'h0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (cnt_reg[i] != 2'h0) cnt_reg[i] <= cnt_reg[i] - 2'h1;
        if (cnt_reg[i] == 2'h1) done_reg[i] <= 1'b1;
        if (mispredict && valid_reg[i] && age(tag_t'(i), head_reg) > age_b) begin
          valid_reg[i] <= 1'b0;
        end
      end
      for (int b = 0; b < NB; b++) begin
        if (pick[b][TW]) begin
          issued_reg[pick[b][TW-1:0]] <= 1'b1;
          cnt_reg[pick[b][TW-1:0]]    <= issue_lat(b, pick[b][TW-1:0]);
        end
      end
      if (sq_pop) cnt_reg[sq_pop_tag] <= sched_pkg::STORE_LAT;
      if (res_ok) done_reg[res_tag] <= 1'b1;
      for (int k = 0; k < sched_pkg::RETIRE_W; k++) begin
        if (k < ret_n) valid_reg[wrap(int'(head_reg) + k)] <= 1'b0;
      end
      if (fire) begin
        for (int s = 0; s < G; s++) begin
          valid_reg[wrap(int'(tail) + s)]  <= 1'b1;
          issued_reg[wrap(int'(tail) + s)] <= slot_kind[s*3 +: 3] == sched_pkg::K_NOP;
          done_reg[wrap(int'(tail) + s)]   <= slot_kind[s*3 +: 3] == sched_pkg::K_NOP;
          cnt_reg[wrap(int'(tail) + s)]    <= 2'h0;
        end
      end
    end
  end

  // Entry payload, written only on insertion
  always_ff @(posedge clk) begin
    if (fire) begin
      for (int s = 0; s < G; s++) begin
        kind_reg[wrap(int'(tail) + s)] <= sched_pkg::uop_kind_e'(slot_kind[s*3 +: 3]);
        lat_reg[wrap(int'(tail) + s)]  <= (slot_lat[s*2 +: 2] == 2'h0) ? 2'h1 : slot_lat[s*2 +: 2];
        occ_reg[wrap(int'(tail) + s)]  <= slot_occ[s];
        last_reg[wrap(int'(tail) + s)] <= slot_last[s];
        pred_reg[wrap(int'(tail) + s)] <= pred_taken[s];
        hidx_reg[wrap(int'(tail) + s)] <= pred_hidx[s*HW +: HW];
      end
    end
  end

  // Head and fill level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head_reg  <= '0;
      count_reg <= '0;
    end else begin
      head_reg  <= wrap(int'(head_reg) + ret_n);
      count_reg <= TW'(count_next);
    end
  end

  // Unit occupancy for non-pipelined operations
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int b = 0; b < NB; b++) busy_reg[b] <= 2'h0;
    end else begin
      for (int b = 0; b < NB; b++) begin
        if (busy_reg[b] != 2'h0) busy_reg[b] <= busy_reg[b] - 2'h1;
        if (pick[b][TW] && (b == sched_pkg::BUS_X || b == sched_pkg::BUS_Y)
            && occ_reg[pick[b][TW-1:0]]) begin
          busy_reg[b] <= issue_lat(b, pick[b][TW-1:0]) - 2'h1;
        end
        if (pick[b][TW] && b == sched_pkg::BUS_FP) busy_reg[b] <= sched_pkg::FP_OCC - 2'h1;
      end
    end
  end

  // Issue and retire reports
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      iss_valid <= '0;
      iss_tag   <= '0;
      ret_valid <= '0;
      ret_tag   <= '0;
    end else begin
      for (int b = 0; b < NB; b++) begin
        iss_valid[b]          <= pick[b][TW];
        iss_tag[b*TW +: TW]   <= pick[b][TW-1:0];
      end
      for (int k = 0; k < sched_pkg::RETIRE_W; k++) begin
        ret_valid[k]          <= k < ret_n;
        ret_tag[k*TW +: TW]   <= wrap(int'(head_reg) + k);
      end
    end
  end

  // Recovery and admission
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flush_valid   <= 1'b0;
      flush_tag     <= '0;
      grp_ready_reg <= 1'b0;
    end else begin
      flush_valid   <= mispredict;
      flush_tag     <= res_tag;
      grp_ready_reg <= !mispredict && count_next <= N - G
                       && icnt + (fire ? gi : 0) <= sched_pkg::MAX_INSTR - G
                       && bcnt + (fire ? gb : 0) <= sched_pkg::MAX_BRANCH - G;
    end
  end
  assign grp_ready = grp_ready_reg;

  store_queue #(
    .DEPTH(SQ_DEPTH),
    .W    (TW)
  ) u_sq (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (pick[sched_pkg::BUS_ST][TW]),
    .in_ready  (sq_ready),
    .in_tag    (pick[sched_pkg::BUS_ST][TW-1:0]),
    .pop_valid (sq_pop),
    .pop_tag   (sq_pop_tag),
    .exec_valid(st_exec_valid),
    .exec_tag  (st_exec_tag)
  );

  branch_predictor u_bp (
    .clk           (clk),
    .rst_n         (rst_n),
    .grp_fire      (fire),
    .grp_pc        (grp_pc),
    .slot_bkind    (slot_bkind),
    .slot_end      (slot_end),
    .slot_disp     (slot_disp),
    .pred_taken    (pred_taken),
    .pred_hidx     (pred_hidx),
    .res_update    (res_ok),
    .res_taken     (res_taken),
    .res_hidx      (hidx_reg[res_tag]),
    .res_mispredict(mispredict),
    .res_target    (res_target),
    .tc_fill_valid (tc_fill_valid),
    .tc_fill_addr  (tc_fill_addr),
    .tc_fill_data  (tc_fill_data),
    .redir_valid   (redir_valid),
    .redir_addr    (redir_addr),
    .tc_hit        (tc_hit),
    .tc_data       (tc_data)
  );
endmodule : ooo_scheduler

// ---- ooo_scheduler_sva.sv ----
// Scheduler port assertions
`timescale 1ns/1ns
module ooo_scheduler_sva (
  // Clock, reset, group
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        grp_valid,
  input wire logic        grp_ready,
  input wire logic [31:0] grp_pc,
  input wire logic [11:0] slot_bkind,
  input wire logic [15:0] slot_end,
  input wire logic [63:0] slot_disp,
  // Issue, retire, recovery
  input wire logic [5:0]  iss_valid,
  input wire logic [29:0] iss_tag,
  input wire logic        res_valid,
  input wire logic [31:0] res_target,
  input wire logic [3:0]  ret_valid,
  input wire logic        flush_valid,
  input wire logic        redir_valid,
  input wire logic [31:0] redir_addr,
  input wire logic        tc_hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence jump_take_s;
    grp_valid && grp_ready && !res_valid && slot_bkind[2:0] == 3'h2;
  endsequence
  ready_reset_a: assert property (!$past(rst_n) |-> !grp_ready)
    else $error("ready after reset");
  retire_order_a: assert property (ret_valid inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("retire gap");
  tag_range_a: assert property (iss_valid[3] |-> iss_tag[19:15] < 5'h18)
    else $error("tag range");
  xy_distinct_a: assert property (
    &iss_valid[4:3] |-> iss_tag[19:15] != iss_tag[24:20]) else $error("dual issue");
  flush_stall_a: assert property (flush_valid |-> redir_valid && !grp_ready)
    else $error("flush stall");
  flush_cause_a: assert property (
    flush_valid |-> $past(res_valid) && redir_addr == $past(res_target)) else $error("flush");
  tc_redir_a: assert property (tc_hit |-> redir_valid)
    else $error("tc hit");
  jump_redir_a: assert property (
    jump_take_s |=> redir_valid && redir_addr == $past(grp_pc) + 32'($past(slot_end[3:0]))
      + 32'(signed'($past(slot_disp[15:0])))) else $error("jump target");
endmodule : ooo_scheduler_sva
bind ooo_scheduler ooo_scheduler_sva chk (.*);

// ---- branch_unit_model.sv ----
// Branch unit stand-in answering each issued branch
`timescale 1ns/1ns
module branch_unit_model (
  // Clock and issued branch
  input  wire logic        clk,
  input  wire logic        br_valid,
  input  wire logic [4:0]  br_tag,
  // Actual outcome
  input  wire logic        taken_in,
  input  wire logic [31:0] target_in,
  // Resolution
  output logic             res_valid = 1'b0,
  output logic [4:0]       res_tag = 5'h00,
  output logic             res_taken = 1'b0,
  output logic [31:0]      res_target = 32'h0000_0000
);
  // Resolve one clock after issue; idle fields toggle
  always @(negedge clk) begin
    res_valid <= br_valid;
    res_tag <= br_valid ? br_tag : ~res_tag;
    res_taken <= br_valid ? taken_in : ~res_taken;
    res_target <= br_valid ? target_in : ~res_target;
  end
endmodule : branch_unit_model

// ---- tb_ooo_scheduler.sv ----
// Self-checking bench for the scheduler
`timescale 1ns/1ns
module tb_ooo_scheduler;
  typedef struct {logic [11:0] kind; logic [3:0] last; logic [5:0] mask;} row_s;
  logic        clk = 1'b0, rst_n = 1'b0, grp_valid = 1'b0, tc_fill_valid = 1'b0;
  logic        grp_ready, res_valid, res_taken, flush_valid, redir_valid, st_exec_valid, tc_hit;
  logic        taken = 1'b1, fl, se;
  logic [3:0]  slot_last = '0, slot_occ = '0, ret_valid;
  logic [4:0]  res_tag, flush_tag, st_exec_tag, st_tag = '0, ft = '1, bt = '0;
  logic [7:0]  slot_lat = '0;
  logic [19:0] ret_tag;
  logic [127:0] tc_data;
  logic [5:0]  iss_valid;
  logic [11:0] slot_kind = '0, slot_bkind = '0;
  logic [15:0] slot_end = '0;
  logic [29:0] iss_tag;
  logic [31:0] grp_pc = '0, target = '0, res_target, redir_addr, ra;
  logic [63:0] slot_disp = '0;
  int          mismatches = 0, n_checks = 0;
  row_s        rows [4] = '{'{12'hF11, 4'hF, 6'h2B}, '{12'h02D, 4'h3, 6'h18},
                            '{12'h192, 4'h7, 6'h0A}, '{12'h000, 4'h0, 6'h00}};
  always #20 clk = ~clk;
  ooo_scheduler dut (.*, .tc_fill_addr(32'h0000_1010), .tc_fill_data('1));
  branch_unit_model bu (.clk(clk), .br_valid(iss_valid[2]), .br_tag(iss_tag[14:10]),
    .taken_in(taken), .target_in(target), .res_valid(res_valid), .res_tag(res_tag),
    .res_taken(res_taken), .res_target(res_target));
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic results;
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // Offer one group and hold it until taken
  task automatic send(input logic [11:0] k, b, input logic [3:0] l, input logic [31:0] pc,
                      input logic [15:0] e, input logic [63:0] d);
    int i;
    @(negedge clk);
    {slot_kind, slot_bkind, slot_last, grp_pc, slot_end, slot_disp} = {k, b, l, pc, e, d};
    grp_valid = 1'b1;
    for (i = 0; i < 50 && grp_ready !== 1'b1; i++) @(negedge clk);
    if (i == 50) begin
      mismatches++;
      results();
    end
    @(negedge clk);
    grp_valid = 1'b0;
  endtask : send
  task automatic drain(input int n);
    int got = 0;
    for (int i = 0; i < 40 && got < n; i++) begin
      @(negedge clk);
      got += $countones(ret_valid);
      if (st_exec_valid === 1'b1) check("store tag", st_exec_tag, st_tag);
      if (ret_valid[1] === 1'b1)
        check("retire order", ret_tag[9:5], (ret_tag[4:0] + 1) % 24);
    end
    check("retired", got, n);
  endtask : drain
  initial begin
    repeat (4) @(negedge clk);
    check("ready in reset", grp_ready, 0);
    rst_n = 1'b1;
    foreach (rows[r]) begin
      send(rows[r].kind, 12'h000, rows[r].last, 32'h0000_0100, 16'h0000, 64'h0);
      @(negedge clk);
      check("issue mask", iss_valid, rows[r].mask);
      if (iss_valid[0] === 1'b1) st_tag = iss_tag[4:0];
      drain(4 - $countones(ret_valid));
    end
    // Two back-to-back multiplies share X for three clocks each
    {slot_lat, slot_occ} = {8'h0F, 4'h3};
    send(12'h024, 12'h000, 4'h3, 32'h0000_0200, 16'h0000, 64'h0);
    {slot_lat, slot_occ} = '0;
    for (int c = 0; c < 4; c++) begin
      @(negedge clk);
      check("multiply occupancy", iss_valid[3], c == 0 || c == 3);
    end
    drain(4);
    tc_fill_valid = 1'b1;
    @(negedge clk);
    tc_fill_valid = 1'b0;
    send(12'h003, 12'h002, 4'h1, 32'h0000_1000, 16'h0002, 64'h0000_0000_0000_0010);
    check("jump target", redir_addr, 32'h0000_1012);
    check("target cache hit", tc_hit, 1);
    check("target cache data", tc_data[31:0], 32'hFFFF_FFFF);
    drain(4);
    send(12'h003, 12'h003, 4'h1, 32'h0000_2000, 16'h0005, 64'h0000_0000_0000_0100);
    check("call target", redir_addr, 32'h0000_2105);
    drain(4);
    target = 32'h0000_2005;
    send(12'h003, 12'h004, 4'h1, 32'h0000_2105, 16'h0001, 64'h0);
    check("return target", redir_addr, 32'h0000_2005);
    drain(4);
    target = 32'h0000_3040;
    send(12'h00B, 12'h001, 4'h3, 32'h0000_3000, 16'h0042, 64'h0);
    fl = 1'b0;
    se = 1'b0;
    repeat (12) begin
      @(negedge clk);
      if (iss_valid[2] === 1'b1) bt = iss_tag[14:10];
      if (flush_valid === 1'b1) begin
        ra = redir_addr;
        ft = flush_tag;
      end
      fl |= flush_valid;
      se |= st_exec_valid;
    end
    check("flush", fl, 1);
    check("flush tag", ft, bt);
    check("wrong path store", se, 0);
    check("recovery target", ra, 32'h0000_3040);
    results();
  end
endmodule : tb_ooo_scheduler
